//--- hw/pmc_pkg.sv
// constants shared by the power mode controller
// Notes on behaviour
// [R1] normal mode: core and all peripherals get clock and run; here only peripherals enabled in pen_r are clocked
// [R2] core-halt bit stops the core, peripherals stay clocked; any interrupt ends idle
// [R3] software selects an internal oscillator as clock before setting stop-clocks
// [R4] suspend halts core and digital peripherals and turns internal oscillators off
// [R5] software disables unused analog parts, then sets the deep power-down bit
// [R6] sleep powers down most nets; pins, ram and registers keep their state
// [R7] suspend and sleep wake on alarm, oscillator failure, port match, comparator rise
// [R8] after any wake the core resumes code where it stopped
// [R9] unused digital peripherals have their clocks gated off
// [R10] after reset the clock is the low-power oscillator divided by eight
// [R11] divider offers eight power-of-two settings from 1 to 128
// [R12] a wake clears the mode request bit and returns to normal mode
package pmc_pkg;
  localparam int ADDR_W = 4;
  localparam int PERIPH_N = 8;
  // register byte addresses
  localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] PU_CFG_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] CLK_SEL_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] PERIPH_EN_ADDR = 4'hC;
  // field positions
  localparam int CORE_HALT_BIT = 0;
  localparam int STOP_CLK_BIT = 0;
  localparam int DEEP_PD_BIT = 1;
  localparam int SRC_LSB = 0;
  localparam int DIV_LSB = 4;
  localparam int STATE_LSB = 8;
  // clock sources
  localparam logic [1:0] SRC_LPOSC = 2'h0;
  localparam logic [1:0] SRC_HFOSC = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  // reset values
  localparam logic [1:0] SRC_RESET = SRC_LPOSC;
  localparam logic [2:0] DIV_RESET = 3'h3;
  localparam logic [PERIPH_N-1:0] PERIPH_RESET = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_SUSPEND = 2'b10,
    MODE_SLEEP = 2'b11
  } pmode_e;
endpackage

//--- hw/wake_if.sv
// wake event carrier between the controller and its edge detector
`timescale 1ns/10ps
`default_nettype none
interface wake_if;
  logic [3:0] raw;
  logic [3:0] pulse;
  modport det (input raw, output pulse);
  modport ctl (output raw, input pulse);
endinterface
`default_nettype wire

//--- hw/wake_sync.sv
// synchronises wake pins and turns them into one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module wake_sync (
  input wire logic clk_i,
  input wire logic reset_n_i,
  wake_if.det w
);
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  // two-stage synchroniser then one stage for edge detection
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
    end else begin
      s1_r <= w.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // rising edge of each source; a level held across sleep does not rewake
  assign w.pulse = s2_r & ~s3_r;
endmodule
`default_nettype wire

//--- hw/power_mode_controller.sv
// power mode sequencer with clock source and divider control
`timescale 1ns/10ps
`default_nettype none
module power_mode_controller
  import pmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic irq_any_i,
  input wire logic rtc_alarm_i,
  input wire logic rtc_fail_i,
  input wire logic port_match_i,
  input wire logic cmp0_i,
  output logic core_clk_en_o,
  output logic dig_clk_en_o,
  output logic [PERIPH_N-1:0] periph_clk_en_o,
  output logic int_osc_en_o,
  output logic power_nets_on_o,
  output logic retain_o,
  output logic [1:0] sys_src_o,
  output logic [2:0] sys_div_o,
  output logic [1:0] mode_o
);
  pmode_e mode_r;
  pmode_e mode_nxt;
  logic halt_r;
  logic stop_r;
  logic deep_r;
  logic [1:0] src_r;
  logic [2:0] div_r;
  logic [PERIPH_N-1:0] pen_r;
  logic ack_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic [31:0] rdata_r;
  wake_if wk ();

  ////////////////////////////////////////////////////////////////////////
  // wake sources pass a synchroniser before use
  assign wk.raw = {cmp0_i, port_match_i, rtc_fail_i, rtc_alarm_i};
  wake_sync u_wake (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .w(wk)
  );

  // interrupt is a level; synchronised only
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end else begin
      irq_s1_r <= irq_any_i;
      irq_s2_r <= irq_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle, then answer
  wire acc = (avs_read_i | avs_write_i) & ~ack_r;
  wire wr_hit = avs_write_i & ack_r;
  wire wr_ctrl = wr_hit & (avs_address_i == PWR_CTRL_ADDR);
  wire wr_cfg = wr_hit & (avs_address_i == PU_CFG_ADDR);
  wire wr_clk = wr_hit & (avs_address_i == CLK_SEL_ADDR);
  wire wr_pen = wr_hit & (avs_address_i == PERIPH_EN_ADDR);
  wire wake_deep = |wk.pulse; // R7
  wire wake_idle = irq_s2_r; // R2
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end

  // read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = READ_ZERO;
    unique case (avs_address_i)
      PWR_CTRL_ADDR: rd_mux[CORE_HALT_BIT] = halt_r;
      PU_CFG_ADDR: begin
        rd_mux[STOP_CLK_BIT] = stop_r;
        rd_mux[DEEP_PD_BIT] = deep_r;
      end
      CLK_SEL_ADDR: begin
        rd_mux[SRC_LSB +: 2] = src_r;
        rd_mux[DIV_LSB +: 3] = div_r;
        rd_mux[STATE_LSB +: 2] = mode_r;
      end
      PERIPH_EN_ADDR: rd_mux[PERIPH_N-1:0] = pen_r;
      default: rd_mux = READ_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_r <= READ_ZERO;
    end else if (acc) begin
      rdata_r <= rd_mux;
    end
  end
  assign avs_readdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // request bits; a wake clears them and wins over a same-cycle write
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      halt_r <= 1'b0;
      stop_r <= 1'b0;
      deep_r <= 1'b0;
    end else begin
      if (mode_r == MODE_IDLE && wake_idle) begin
        halt_r <= 1'b0; // R12
      end else if (wr_ctrl) begin
        halt_r <= avs_writedata_i[CORE_HALT_BIT]; // R2
      end
      if ((mode_r == MODE_SUSPEND || mode_r == MODE_SLEEP) && wake_deep) begin
        stop_r <= 1'b0; // R12
        deep_r <= 1'b0;
      end else if (wr_cfg) begin
        stop_r <= avs_writedata_i[STOP_CLK_BIT];
        deep_r <= avs_writedata_i[DEEP_PD_BIT];
      end
    end
  end

  // clock source, divider and per-peripheral gating
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      src_r <= SRC_RESET; // R10
      div_r <= DIV_RESET; // R10
      pen_r <= PERIPH_RESET;
    end else begin
      if (wr_clk) begin
        src_r <= avs_writedata_i[SRC_LSB +: 2];
        div_r <= avs_writedata_i[DIV_LSB +: 3]; // R11
      end
      if (wr_pen) begin
        pen_r <= avs_writedata_i[PERIPH_N-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode sequencer; sleep takes priority over suspend over idle
  wire src_ok = (src_r == SRC_LPOSC) || (src_r == SRC_HFOSC); // R3
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_NORMAL: begin
        if (deep_r) begin
          mode_nxt = MODE_SLEEP;
        end else if (stop_r && src_ok) begin
          mode_nxt = MODE_SUSPEND;
        end else if (halt_r) begin
          mode_nxt = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (wake_idle) begin
          mode_nxt = MODE_NORMAL; // R8
        end
      end
      MODE_SUSPEND, MODE_SLEEP: begin
        if (wake_deep) begin
          mode_nxt = MODE_NORMAL; // R7
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_r <= MODE_NORMAL;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enables; registers stay in this always-on domain so state is kept
  wire is_norm = (mode_r == MODE_NORMAL);
  wire is_idle = (mode_r == MODE_IDLE);
  wire is_deep = (mode_r == MODE_SUSPEND) || (mode_r == MODE_SLEEP);
  assign core_clk_en_o = is_norm; // R1 R2 R4
  assign dig_clk_en_o = ~is_deep; // R1 R4
  assign periph_clk_en_o = is_deep ? '0 : pen_r; // R9
  assign int_osc_en_o = ~is_deep; // R4
  assign power_nets_on_o = (mode_r != MODE_SLEEP); // R6
  assign retain_o = (mode_r == MODE_SLEEP); // R6
  assign sys_src_o = src_r;
  assign sys_div_o = div_r;
  assign mode_o = mode_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_idle_exit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_idle && wake_idle |=> is_norm && !halt_r) // R12
    else $error("idle did not end on interrupt");
  chk_deep_exit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_deep && wake_deep |=> is_norm && !stop_r && !deep_r) // R7
    else $error("low power mode did not end on wake");
  chk_osc_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_deep |-> !int_osc_en_o && !core_clk_en_o && periph_clk_en_o == '0) // R4
    else $error("oscillator or clocks on in suspend");
  chk_idle_periph: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_idle |-> dig_clk_en_o && !core_clk_en_o) // R2
    else $error("idle clocking wrong");
  chk_reset_clock: assert property (@(posedge clk_i)
    !reset_n_i |=> sys_src_o == SRC_LPOSC && sys_div_o == DIV_RESET) // R10
    else $error("reset clock not divided low power oscillator");
  chk_sleep_entry: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_norm && deep_r |=> mode_r == MODE_SLEEP && retain_o) // R6
    else $error("sleep not entered");
  chk_suspend_src: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_norm && stop_r && !deep_r && !src_ok |=> !is_deep) // R3
    else $error("suspend from external clock");
  chk_normal_run: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    is_norm |-> core_clk_en_o && dig_clk_en_o && power_nets_on_o) // R1
    else $error("normal mode not fully clocked");
  cov_idle: cover property (@(posedge clk_i) is_idle ##[1:50] is_norm);
  cov_suspend: cover property (@(posedge clk_i) mode_r == MODE_SUSPEND ##[1:50] is_norm);
  cov_sleep: cover property (@(posedge clk_i) mode_r == MODE_SLEEP ##[1:50] is_norm);
endmodule
`default_nettype wire

//--- testbench/power_mode_controller_tb_top.sv
// self-checking bench for the power mode controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module power_mode_controller_tb_top;
  import pmc_pkg::*;
  logic clk_i, reset_n_i, avs_read_i, avs_write_i, irq_any_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic avs_waitrequest_o, core_clk_en_o, dig_clk_en_o, int_osc_en_o, power_nets_on_o, retain_o;
  logic [PERIPH_N-1:0] periph_clk_en_o;
  logic [1:0] sys_src_o, mode_o;
  logic [2:0] sys_div_o;
  logic [3:0] wake_pins;
  int error_cnt, samples_checked, cycles;
  power_mode_controller power_mode_controller_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_any_i(irq_any_i), .rtc_alarm_i(wake_pins[0]),
    .rtc_fail_i(wake_pins[1]), .port_match_i(wake_pins[2]), .cmp0_i(wake_pins[3]),
    .core_clk_en_o(core_clk_en_o), .dig_clk_en_o(dig_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .int_osc_en_o(int_osc_en_o), .power_nets_on_o(power_nets_on_o), .retain_o(retain_o),
    .sys_src_o(sys_src_o), .sys_div_o(sys_div_o), .mode_o(mode_o));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the ceiling is far above the few hundred cycles needed
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // avalon master: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= we;
    avs_read_i <= !we;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    #1;
  endtask
  // bounded wait for a mode; a miss shows up in the following compare
  task automatic wait_mode(input pmode_e m);
    for (int n = 0; n < 20 && mode_o !== m; n++) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    `CHK(sys_src_o, SRC_LPOSC)
    `CHK(sys_div_o, 3'h3)
    `CHK({core_clk_en_o, dig_clk_en_o, int_osc_en_o, power_nets_on_o, retain_o}, 5'h1e)
    `CHK(periph_clk_en_o, 8'h00)
    bus(1'b0, CLK_SEL_ADDR, 32'h0000_0000);
    `CHK(rd, 32'h0000_0030)
    bus(1'b1, 4'h1, 32'hffff_ffff);
    bus(1'b0, 4'h1, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // a write to a hole must leave the clock setup untouched
    bus(1'b0, CLK_SEL_ADDR, 32'h0000_0000);
    `CHK(rd, 32'h0000_0030)
  endtask
  // walk every divider setting; finish on the precision oscillator undivided
  task automatic t_divider();
    for (int i = 7; i >= 0; i--) begin
      bus(1'b1, CLK_SEL_ADDR, 32'h0000_0001 | (i << 4));
      `CHK(sys_div_o, 3'(i))
      bus(1'b0, CLK_SEL_ADDR, 32'h0000_0000);
      `CHK(rd[6:0], {3'(i), 4'h1})
    end
    `CHK(sys_src_o, SRC_HFOSC)
  endtask
  task automatic t_idle();
    bus(1'b1, PERIPH_EN_ADDR, 32'h0000_00a5);
    `CHK(periph_clk_en_o, 8'ha5)
    bus(1'b1, PWR_CTRL_ADDR, 32'h0000_0001);
    wait_mode(MODE_IDLE);
    `CHK({mode_o, core_clk_en_o, dig_clk_en_o}, {MODE_IDLE, 2'b01})
    `CHK(periph_clk_en_o, 8'ha5)
    bus(1'b0, CLK_SEL_ADDR, 32'h0000_0000);
    `CHK(rd[9:8], MODE_IDLE)
    @(posedge clk_i);
    irq_any_i <= 1'b1;
    wait_mode(MODE_NORMAL);
    `CHK({mode_o, core_clk_en_o}, {MODE_NORMAL, 1'b1})
    bus(1'b0, PWR_CTRL_ADDR, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    @(posedge clk_i);
    irq_any_i <= 1'b0;
  endtask
  // a suspend request while on the external clock stays pending and can be withdrawn
  task automatic t_ext_hold();
    bus(1'b1, CLK_SEL_ADDR, 32'h0000_0002);
    `CHK(sys_src_o, SRC_EXT)
    bus(1'b1, PU_CFG_ADDR, 32'h0000_0001);
    repeat (4) @(posedge clk_i);
    #1;
    `CHK({mode_o, int_osc_en_o}, {MODE_NORMAL, 1'b1})
    bus(1'b1, PU_CFG_ADDR, 32'h0000_0000);
    bus(1'b1, CLK_SEL_ADDR, 32'h0000_0001);
    `CHK(mode_o, MODE_NORMAL)
  endtask
  // suspend then sleep, each woken once by every one of the four sources
  task automatic t_deep();
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 4; k++) begin
        bus(1'b1, PU_CFG_ADDR, (m == 1) ? 32'h0000_0002 : 32'h0000_0001);
        wait_mode(m == 1 ? MODE_SLEEP : MODE_SUSPEND);
        `CHK({core_clk_en_o, dig_clk_en_o, int_osc_en_o}, 3'b000)
        `CHK(periph_clk_en_o, 8'h00)
        `CHK({power_nets_on_o, retain_o}, (m == 1) ? 2'b01 : 2'b10)
        @(posedge clk_i);
        wake_pins[k] <= 1'b1;
        wait_mode(MODE_NORMAL);
        `CHK({mode_o, core_clk_en_o}, {MODE_NORMAL, 1'b1})
        `CHK(periph_clk_en_o, 8'ha5)
        bus(1'b0, PU_CFG_ADDR, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        @(posedge clk_i);
        wake_pins[k] <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n_i, avs_read_i, avs_write_i, irq_any_i} = 4'h0;
    avs_address_i = '0;
    avs_writedata_i = 32'h0000_0000;
    wake_pins = 4'h0;
    error_cnt = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    t_reset();
    t_divider();
    t_idle();
    t_ext_hold();
    t_deep();
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
